// File: logic/eeprom_bus_target.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_bus_target
  import eeprom_link_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = WRITE_CYCLE_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  eeprom_link_if.device link,
  output logic [7:0] rx_word,
  output logic rx_valid,
  output logic standby,
  output logic busy,
  output logic is_read
);
  if (WRITE_CYCLES < 1 || WRITE_CYCLES > WRITE_CYCLE_CYC) begin : g_bad_cyc
    $error("WRITE_CYCLES out of range");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_BITS, ST_ACK, ST_HOLD
  } phase_e;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [2:0] scl_sync_q, scl_sync_d;
  logic [2:0] sda_sync_q, sda_sync_d;
  logic scl_lvl_q, scl_lvl_d;
  logic sda_lvl_q, sda_lvl_d;

  always_comb begin
    scl_sync_d = {scl_sync_q[1:0], link.scl};
    sda_sync_d = {sda_sync_q[1:0], link.sda};
    scl_lvl_d = scl_lvl_q;
    sda_lvl_d = sda_lvl_q;
    if (scl_sync_q[1] == scl_sync_q[2]) begin
      scl_lvl_d = scl_sync_q[2];
    end
    if (sda_sync_q[1] == sda_sync_q[2]) begin
      sda_lvl_d = sda_sync_q[2];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      scl_lvl_q <= 1'b1;
      sda_lvl_q <= 1'b1;
    end else begin
      scl_sync_q <= scl_sync_d;
      sda_sync_q <= sda_sync_d;
      scl_lvl_q <= scl_lvl_d;
      sda_lvl_q <= sda_lvl_d;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_lvl_d & ~scl_lvl_q;
  assign scl_fall = ~scl_lvl_d & scl_lvl_q;
  // SDA edge with SCL steady high is a bus condition
  assign start_det = scl_lvl_q & scl_lvl_d & sda_lvl_q & ~sda_lvl_d;
  assign stop_det = scl_lvl_q & scl_lvl_d & ~sda_lvl_q & sda_lvl_d;

  ////////////////////////////////////////////////////////////////////////////
  // Protocol engine
  phase_e phase_q, phase_d;
  logic [3:0] bit_cnt_q, bit_cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] rx_word_d;
  logic rx_valid_d;
  logic first_q, first_d;
  logic is_read_d;
  logic sda_oe_q, sda_oe_d;
  logic standby_q, standby_d;
  logic wrote_q, wrote_d;
  logic busy_d;
  logic [31:0] wcnt_q, wcnt_d;

  always_comb begin
    phase_d = phase_q;
    bit_cnt_d = bit_cnt_q;
    shift_d = shift_q;
    rx_word_d = rx_word;
    rx_valid_d = 1'b0;
    first_d = first_q;
    is_read_d = is_read;
    sda_oe_d = sda_oe_q;
    standby_d = standby_q;
    wrote_d = wrote_q;
    busy_d = busy;
    wcnt_d = wcnt_q;
    if (busy) begin
      // Bus traffic ignored while programming
      sda_oe_d = 1'b0;
      phase_d = ST_IDLE;
      if (wcnt_q == 32'(WRITE_CYCLES - 1)) begin
        busy_d = 1'b0;
        standby_d = 1'b1;
        wcnt_d = 32'h0000_0000;
      end else begin
        wcnt_d = wcnt_q + 32'h0000_0001;
      end
    end else if (start_det) begin
      // Any START drops a partial transfer
      phase_d = ST_BITS;
      bit_cnt_d = BIT_CNT_RESET;
      first_d = 1'b1;
      sda_oe_d = 1'b0;
      standby_d = 1'b0;
      wrote_d = 1'b0;
    end else if (stop_det) begin
      phase_d = ST_IDLE;
      sda_oe_d = 1'b0;
      if (wrote_q && !is_read) begin
        busy_d = 1'b1;
        wcnt_d = 32'h0000_0000;
      end else begin
        standby_d = 1'b1;
      end
      wrote_d = 1'b0;
    end else begin
      case (phase_q)
        ST_IDLE: begin
        end
        ST_BITS: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_lvl_q};
            bit_cnt_d = bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == 4'(WORD_BITS)) begin
            sda_oe_d = 1'b1;
            phase_d = ST_ACK;
            rx_word_d = shift_q;
            rx_valid_d = 1'b1;
            if (first_q) begin
              is_read_d = shift_q[RW_BIT_POS];
            end else if (!is_read) begin
              wrote_d = 1'b1;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            sda_oe_d = 1'b0;
            first_d = 1'b0;
            bit_cnt_d = BIT_CNT_RESET;
            // Read data path not present: hold off in read
            phase_d = (is_read && !first_q) ? ST_HOLD : ST_BITS;
            if (is_read) begin
              phase_d = ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
        end
        default: phase_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_q <= ST_IDLE;
      bit_cnt_q <= BIT_CNT_RESET;
      shift_q <= WORD_RESET;
      rx_word <= WORD_RESET;
      rx_valid <= 1'b0;
      first_q <= 1'b0;
      is_read <= 1'b0;
      sda_oe_q <= 1'b0;
      standby_q <= 1'b1;
      wrote_q <= 1'b0;
      busy <= 1'b0;
      wcnt_q <= 32'h0000_0000;
    end else begin
      phase_q <= phase_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
      rx_word <= rx_word_d;
      rx_valid <= rx_valid_d;
      first_q <= first_d;
      is_read <= is_read_d;
      sda_oe_q <= sda_oe_d;
      standby_q <= standby_d;
      wrote_q <= wrote_d;
      busy <= busy_d;
      wcnt_q <= wcnt_d;
    end
  end

  assign link.sda_dev_oe = sda_oe_q;
  assign standby = standby_q;
endmodule
`default_nettype wire

// File: logic/eeprom_link_pkg.sv
package eeprom_link_pkg;
  localparam int unsigned CORE_CLK_MHZ = 250;
  localparam int unsigned WORD_BITS = 8;
  localparam int unsigned ACK_BIT = 9;
  localparam int unsigned RW_BIT_POS = 0;
  localparam int unsigned WRITE_CYCLE_MS = 5;
  localparam int unsigned WRITE_CYCLE_CYC = WRITE_CYCLE_MS * 1000 * CORE_CLK_MHZ;
  localparam int unsigned SCL_HALF_CYC = 20;
  localparam logic [7:0] WORD_RESET = 8'h00;
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;
endpackage

// File: logic/eeprom_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface eeprom_link_if;
  logic scl;
  logic sda_dev_oe;
  logic sda_ctl_oe;
  logic sda;
  // Open-drain wire: external pull-up, both sides only pull low
  assign sda = ~(sda_dev_oe | sda_ctl_oe);
  modport device (input scl, input sda, output sda_dev_oe);
  modport controller (output scl, input sda, output sda_ctl_oe);
endinterface
`default_nettype wire

// File: logic/eeprom_bus_controller.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_bus_controller
  import eeprom_link_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = SCL_HALF_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  eeprom_link_if.controller link,
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic [7:0] req_data,
  output logic req_ready,
  output logic ack_seen,
  output logic done
);
  // req_kind: 0 START+byte, 1 byte, 2 STOP, 3 recovery
  if (HALF_CYCLES < 2 || HALF_CYCLES > 65536) begin : g_bad_half
    $error("HALF_CYCLES out of range");
  end

  typedef enum logic [3:0] {
    C_IDLE, C_START, C_LOW, C_HIGH, C_STOP_LOW, C_STOP_HIGH, C_REC_CLK,
    C_REC_START, C_RISE
  } cstate_e;

  cstate_e st_q, st_d;
  logic [15:0] div_q, div_d;
  logic tick;
  logic [8:0] sh_q, sh_d;
  logic [3:0] cnt_q, cnt_d;
  logic scl_q, scl_d, oe_q, oe_d;
  logic ack_d, done_d, rdy_d;
  logic rec_q, rec_d;

  assign tick = (div_q == 16'(HALF_CYCLES - 1));

  always_comb begin
    st_d = st_q;
    div_d = tick ? 16'h0000 : div_q + 16'h0001;
    sh_d = sh_q;
    cnt_d = cnt_q;
    scl_d = scl_q;
    oe_d = oe_q;
    ack_d = ack_seen;
    done_d = 1'b0;
    rdy_d = req_ready;
    rec_d = rec_q;
    case (st_q)
      C_IDLE: begin
        rdy_d = 1'b1;
        if (req_valid && req_ready) begin
          rdy_d = 1'b0;
          sh_d = {req_data, 1'b1};
          cnt_d = 4'h0;
          rec_d = (req_kind == 2'd3);
          case (req_kind)
            2'd1: st_d = C_LOW;
            2'd2: st_d = C_STOP_LOW;
            default: st_d = C_START;
          endcase
        end
      end
      C_START: if (tick) begin
        if (scl_q && !oe_q) begin
          oe_d = 1'b1;
        end else if (scl_q) begin
          scl_d = 1'b0;
          st_d = rec_q ? C_REC_CLK : C_LOW;
        end else begin
          scl_d = 1'b1;
          oe_d = 1'b0;
        end
      end
      C_LOW: if (tick) begin
        // SDA changes only with SCL low, one tick before the rise
        oe_d = ~sh_q[8];
        st_d = C_RISE;
      end
      C_RISE: if (tick) begin
        scl_d = 1'b1;
        st_d = C_HIGH;
      end
      C_HIGH: if (tick) begin
        scl_d = 1'b0;
        if (cnt_q == 4'(ACK_BIT - 1)) begin
          ack_d = ~link.sda;
          done_d = 1'b1;
          oe_d = 1'b0;
          st_d = C_IDLE;
        end else begin
          sh_d = {sh_q[7:0], 1'b1};
          cnt_d = cnt_q + 4'h1;
          st_d = C_LOW;
        end
      end
      C_REC_CLK: if (tick) begin
        // Let SDA go under low SCL before the nine clocks
        if (oe_q) begin
          oe_d = 1'b0;
        end else begin
          scl_d = ~scl_q;
          if (scl_q) begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == 4'(ACK_BIT - 1)) st_d = C_REC_START;
          end
        end
      end
      C_REC_START: if (tick) begin
        if (!scl_q) begin
          scl_d = 1'b1;
        end else begin
          // Second START, then STOP with SCL still high
          oe_d = 1'b1;
          rec_d = 1'b0;
          cnt_d = 4'h0;
          st_d = C_STOP_LOW;
        end
      end
      C_STOP_LOW: if (tick) begin
        // SDA low under low SCL first, then SCL high
        if (scl_q && !oe_q) begin
          scl_d = 1'b0;
        end else if (!oe_q) begin
          oe_d = 1'b1;
        end else if (!scl_q) begin
          scl_d = 1'b1;
        end else begin
          st_d = C_STOP_HIGH;
        end
      end
      C_STOP_HIGH: if (tick) begin
        oe_d = 1'b0;
        done_d = 1'b1;
        st_d = C_IDLE;
      end
      default: st_d = C_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= C_IDLE;
      div_q <= 16'h0000;
      sh_q <= 9'h1ff;
      cnt_q <= 4'h0;
      scl_q <= 1'b1;
      oe_q <= 1'b0;
      ack_seen <= 1'b0;
      done <= 1'b0;
      req_ready <= 1'b0;
      rec_q <= 1'b0;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      scl_q <= scl_d;
      oe_q <= oe_d;
      ack_seen <= ack_d;
      done <= done_d;
      req_ready <= rdy_d;
      rec_q <= rec_d;
    end
  end

  assign link.scl = scl_q;
  assign link.sda_ctl_oe = oe_q;
endmodule
`default_nettype wire

// File: sim/eeprom_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_link_monitor #(
  parameter int unsigned WRITE_CYCLES = 100
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_oe,
  input wire logic rx_valid,
  input wire logic busy,
  input wire logic standby,
  input wire logic is_read
);
  logic scl_q, sda_q, oe_q, start_w, stop_w;
  logic [3:0] rise_q, rise_d;
  int unsigned busy_q, busy_d;
  assign start_w = scl && scl_q && sda_q && !sda;
  assign stop_w = scl && scl_q && !sda_q && sda;
  // SCL rises since START or since the last ACK ended
  always_comb begin
    rise_d = rise_q;
    busy_d = busy ? busy_q + 1 : 0;
    if (start_w) begin
      rise_d = 4'h0;
    end else if (scl && !scl_q) begin
      rise_d = rise_q + 4'h1;
    end else if (oe_q && !sda_dev_oe) begin
      rise_d = 4'h0;
    end
  end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      oe_q <= 1'b0;
      rise_q <= 4'h0;
      busy_q <= 0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      oe_q <= sda_dev_oe;
      rise_q <= rise_d;
      busy_q <= busy_d;
    end
  end
  //////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_dev_edge_low: assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("device SDA moved with SCL high");
  a_no_joint_edge: assert property (!($changed(sda) && $changed(scl)))
    else $error("SDA and SCL changed together");
  a_reset_standby: assert property ($fell(sys_rst) |-> standby)
    else $error("no standby after reset");
  a_busy_silent: assert property (busy |-> !sda_dev_oe)
    else $error("device drove SDA while busy");
  a_write_bound: assert property (busy_q <= WRITE_CYCLES)
    else $error("write cycle too long");
  a_wr_end_standby: assert property ($fell(busy) |-> ##[0:4] standby)
    else $error("no standby after write cycle");
  a_rx_acks: assert property (rx_valid |-> ##[0:4] sda_dev_oe)
    else $error("word not acknowledged");
  a_ack_eighth: assert property ($rose(sda_dev_oe) |-> rise_q == 4'h8)
    else $error("ACK not after eight clocks");
  a_read_stop: assert property (stop_w && is_read |-> ##[1:8] standby)
    else $error("no standby after read STOP");
  cover property ($rose(busy));
  cover property (rx_valid);
  cover property (start_w);
  cover property (stop_w && is_read);
endmodule
`default_nettype wire

// File: sim/eeprom_twowire_bus_front_end_tb.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_twowire_bus_front_end_tb;
  import eeprom_link_pkg::*;
  localparam int unsigned WCYC = 2000;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  logic [1:0] req_kind = 2'h0;
  logic [7:0] req_data = 8'h00;
  logic req_ready, ack_seen, done, rx_valid, standby, busy, is_read;
  logic [7:0] rx_word, a;
  logic [7:0] lfsr_q = 8'h0b;
  logic [7:0] word_q[$];
  logic [1:0] ack_q[$];
  int err_total = 0;
  int comparisons = 0;
  eeprom_link_if eeprom_link_if_i ();
  eeprom_bus_target #(.WRITE_CYCLES(WCYC)) eeprom_bus_target_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .link(eeprom_link_if_i),
    .rx_word(rx_word), .rx_valid(rx_valid), .standby(standby),
    .busy(busy), .is_read(is_read));
  eeprom_bus_controller eeprom_bus_controller_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .link(eeprom_link_if_i),
    .req_valid(req_valid), .req_kind(req_kind), .req_data(req_data),
    .req_ready(req_ready), .ack_seen(ack_seen), .done(done));
  eeprom_link_monitor #(.WRITE_CYCLES(WCYC)) eeprom_link_monitor_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .scl(eeprom_link_if_i.scl),
    .sda(eeprom_link_if_i.sda), .sda_dev_oe(eeprom_link_if_i.sda_dev_oe),
    .rx_valid(rx_valid), .busy(busy), .standby(standby),
    .is_read(is_read));
  always #2 core_clk = ~core_clk;
  //////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    lfsr_q = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    return lfsr_q;
  endfunction
  task automatic tally_and_finish();
    $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded wait; running out counts as a mismatch
  task automatic wait_for(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    comparisons++;
    while (s !== v) begin
      @(negedge core_clk);
      n++;
      if (n > lim) begin
        err_total++;
        $display("BAD t=%0t got=%h exp=%h", $time, s, v);
        tally_and_finish();
      end
    end
  endtask
  // ack 2'h2 means the answer is not compared
  task automatic send(input logic [1:0] k, input logic [7:0] d,
                      input logic [1:0] ack, input logic rx);
    ack_q.push_back(ack);
    if (rx) begin
      word_q.push_back(d);
    end
    @(negedge core_clk);
    req_valid = 1'b1;
    req_kind = k;
    req_data = d;
    // Held until req_ready is seen settled at a falling edge
    wait_for(req_ready, 1'b1, 100);
    @(negedge core_clk);
    req_valid = 1'b0;
    wait_for(done, 1'b1, 1000);
  endtask
  //////////////////////////////////////////////////////////////////////
  always @(negedge core_clk) begin
    if (rx_valid === 1'b1) begin
      check(rx_word, word_q.size() > 0 ? word_q.pop_front() : 8'hxx);
    end
    if (done === 1'b1) begin
      if (ack_q.size() == 0) begin
        check({7'h00, ack_seen}, 8'hxx);
      end else if (ack_q[0][1] == 1'b0) begin
        check({7'h00, ack_seen}, {6'h00, ack_q.pop_front()});
      end else begin
        void'(ack_q.pop_front());
      end
    end
  end
  initial begin
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
    check({7'h00, standby}, 8'h01);
    a = rnd() & 8'hfe;
    send(2'h0, a, 2'h1, 1'b1);
    check({7'h00, is_read}, 8'h00);
    send(2'h1, rnd(), 2'h1, 1'b1);
    send(2'h1, rnd(), 2'h1, 1'b1);
    send(2'h2, 8'h00, 2'h2, 1'b0);
    wait_for(busy, 1'b1, 16);
    $display("write test done");
    send(2'h0, a, 2'h0, 1'b0);
    send(2'h2, 8'h00, 2'h2, 1'b0);
    wait_for(busy, 1'b0, WCYC);
    check({7'h00, standby}, 8'h01);
    $display("busy test done");
    send(2'h0, a, 2'h1, 1'b1);
    send(2'h0, a | 8'h01, 2'h1, 1'b1);
    check({7'h00, is_read}, 8'h01);
    send(2'h2, 8'h00, 2'h2, 1'b0);
    wait_for(standby, 1'b1, 16);
    $display("read test done");
    send(2'h0, a, 2'h1, 1'b1);
    // Nine released clocks: eight read as all ones, the device ACKs the ninth
    send(2'h3, 8'hff, 2'h2, 1'b1);
    send(2'h0, a | 8'h01, 2'h1, 1'b1);
    send(2'h2, 8'h00, 2'h2, 1'b0);
    wait_for(standby, 1'b1, 16);
    check(8'(word_q.size() + ack_q.size()), 8'h00);
    $display("recovery test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
